// ---- rtl/dmsm_consts.svh ----
`ifndef DMSM_CONSTS_SVH
`define DMSM_CONSTS_SVH
// Data space: user RAM outside the control window, registers inside it.
`define DMSM_RAM_DEPTH      448
`define DMSM_CTRL_LO        9'h0c0
`define DMSM_CTRL_HI        9'h0ff
// Stack page base address; the 8-bit pointer is the low byte.
`define DMSM_STACK_PAGE     1'b1
// Vector table base and slot indices (two bytes per slot).
`define DMSM_VEC_BASE       16'hffe0
`define DMSM_VEC_SERIAL     4'h2
`define DMSM_VEC_INTERVAL   4'h3
`define DMSM_VEC_WATCHDOG   4'h4
`define DMSM_VEC_CONVERTER  4'h5
`define DMSM_VEC_TIMER1     4'ha
`define DMSM_VEC_TIMER0     4'hb
`define DMSM_VEC_EXT1       4'hc
`define DMSM_VEC_EXT0       4'hd
`define DMSM_VEC_RESET      4'hf
`endif

// ---- rtl/dmsm_pkg.sv ----
package dmsm_pkg;
    // Stack operations that the core requests.
    typedef enum logic [2:0] {
        DMSM_OP_NONE  = 3'b000,
        DMSM_OP_CALL  = 3'b001,
        DMSM_OP_IRQ   = 3'b010,
        DMSM_OP_RET   = 3'b011,
        DMSM_OP_INTERRUPT_RETURN_INSTR  = 3'b100
    } dmsm_op_e;
    // Source of an interrupt, used to pick a vector.
    typedef enum logic [3:0] {
        DMSM_SRC_SERIAL    = 4'h2,
        DMSM_SRC_INTERVAL  = 4'h3,
        DMSM_SRC_WATCHDOG  = 4'h4,
        DMSM_SRC_CONVERTER = 4'h5,
        DMSM_SRC_TIMER1    = 4'ha,
        DMSM_SRC_TIMER0    = 4'hb,
        DMSM_SRC_EXT1      = 4'hc,
        DMSM_SRC_EXT0      = 4'hd,
        DMSM_SRC_RESET     = 4'hf
    } dmsm_src_e;
endpackage

// ---- rtl/dmsm_ram.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dmsm_consts.svh"
// Byte-wide user RAM with a registered read.
module dmsm_ram #(
    parameter int DEPTH = `DMSM_RAM_DEPTH
) (
    input  wire logic clock,
    dmsm_ram_if.mem   port
);
    import dmsm_pkg::*;
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rd_q;

    initial begin
        if (DEPTH < 1 || DEPTH > 512)
            $error("dmsm_ram: depth out of range");
    end

    // Stores a byte and reads the addressed byte one cycle later.
    always_ff @(posedge clock)
    begin
        if (port.we && int'(port.addr) < DEPTH)
            mem_q[port.addr] <= port.wdata;
        rd_q <= (int'(port.addr) < DEPTH) ? mem_q[port.addr] : 8'h00;
    end

    assign port.rdata = rd_q;
endmodule // dmsm_ram
`default_nettype wire

// ---- rtl/dmsm_ram_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Byte port between the sequencer and the user RAM.
interface dmsm_ram_if;
    logic       we;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ---- rtl/dmsm_top.sv ----
// How it works
// - Data space splits into user RAM with stack, and control registers.
// - User RAM holds 448 bytes that read and write.
// - Control registers decode only at addresses 0c0h through 0ffh.
// - Unused control addresses read arbitrary data; writes have no defined effect.
// - Call or interrupt pushes the return address before control moves.
// - Plain return reloads only the program counter from the stack.
// - Interrupt return reloads program counter and status flags.
// - Pointer decrements after each push, increments before each pop.
// - Vectors are two-byte slots from ffe0h in documented order.
// - Stack lives in page 100h to 1ffh, low byte from pointer.
`timescale 1ns/1ps
`default_nettype none
`include "dmsm_consts.svh"
module dmsm_top (
    input  wire logic                clock,
    input  wire logic                arst_n,
    // Core data access port.
    input  wire logic                data_req,
    input  wire logic                data_we,
    input  wire logic [8:0]          data_addr,
    input  wire logic [7:0]          data_wdata,
    output logic      [7:0]          data_rdata,
    output logic                     data_ack,
    // Control register window towards the peripherals.
    output logic                     ctrl_sel,
    output logic                     ctrl_we,
    output logic      [5:0]          ctrl_index,
    output logic      [7:0]          ctrl_wdata,
    input  wire logic [7:0]          ctrl_rdata,
    // Stack pointer load from the core.
    input  wire logic                stack_pointer_load,
    input  wire logic [7:0]          stack_pointer_value,
    output logic      [7:0]          stack_pointer,
    // Stack operation request.
    input  wire dmsm_pkg::dmsm_op_e  stack_op,
    input  wire dmsm_pkg::dmsm_src_e irq_src,
    input  wire logic [15:0]         program_counter,
    input  wire logic [7:0]          status_flags,
    output logic                     stack_busy,
    output logic                     stack_done,
    output logic      [15:0]         vector_addr,
    output logic      [15:0]         restored_pc,
    output logic      [7:0]          restored_flags,
    output logic                     restored_flags_valid
);
    import dmsm_pkg::*;

    typedef enum logic [2:0] {
        DMSM_ST_IDLE = 3'b000,
        DMSM_ST_PUSH = 3'b001,
        DMSM_ST_POPA = 3'b010,
        DMSM_ST_POPW = 3'b011,
        DMSM_ST_DONE = 3'b100
    } dmsm_state_e;

    dmsm_ram_if ram_bus ();

    dmsm_state_e state_q;
    logic [7:0]  sp_q;
    logic [1:0]  left_q;
    logic [1:0]  total_q;
    logic [23:0] shreg_q;
    logic        flags_q;
    logic        ack_q;
    logic        ctrl_rd_q;
    logic [7:0]  ctrl_rd_data_q;
    logic [15:0] vec_q;
    logic [15:0] rpc_q;
    logic [7:0]  rfl_q;
    logic        rflv_q;
    logic        done_q;
    logic        in_ctrl;

    // Picks the RAM address of a stack slot inside the stack page.
    function automatic logic [8:0] stack_addr(input logic [7:0] sp);
        stack_addr = {`DMSM_STACK_PAGE, sp};
    endfunction

    // Folds addresses above the control window down onto the RAM cells,
    // so that the 448 bytes cover 000h-0bfh and the whole stack page.
    function automatic logic [8:0] ram_index(input logic [8:0] a);
        ram_index = a[8] ? a - (`DMSM_CTRL_HI - `DMSM_CTRL_LO + 9'h001)
                         : a;
    endfunction

    // True when an address falls in the control register window.
    function automatic logic is_ctrl(input logic [8:0] a);
        is_ctrl = (a >= `DMSM_CTRL_LO) && (a <= `DMSM_CTRL_HI);
    endfunction

    dmsm_ram #(
        .DEPTH (`DMSM_RAM_DEPTH)
    ) u_ram (
        .clock (clock),
        .port  (ram_bus.mem)
    );

    // Data accesses split between the RAM and the control window.
    assign in_ctrl    = is_ctrl(data_addr);
    assign ctrl_sel   = data_req && in_ctrl && state_q == DMSM_ST_IDLE;
    assign ctrl_we    = ctrl_sel && data_we;
    assign ctrl_index = data_addr[5:0];
    assign ctrl_wdata = data_wdata;

    // Stack sequencing owns the RAM port in PUSH and POPA; otherwise the core address, with core writes only when idle.
    always_comb
    begin
        ram_bus.we    = 1'b0;
        ram_bus.addr  = ram_index(data_addr);
        ram_bus.wdata = data_wdata;
        if (state_q == DMSM_ST_PUSH)
        begin
            ram_bus.we    = 1'b1;
            ram_bus.addr  = ram_index(stack_addr(sp_q));
            ram_bus.wdata = shreg_q[23:16];
        end
        else if (state_q == DMSM_ST_POPA)
        begin
            ram_bus.addr = ram_index(stack_addr(sp_q));
        end
        else if (state_q == DMSM_ST_IDLE)
        begin
            ram_bus.we = data_req && data_we && !in_ctrl;
        end
    end

    // Core access answer: one cycle after the request, data registered.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_q          <= 1'b0;
            ctrl_rd_q      <= 1'b0;
            ctrl_rd_data_q <= 8'h00;
        end
        else
        begin
            ack_q          <= data_req && state_q == DMSM_ST_IDLE;
            ctrl_rd_q      <= in_ctrl;
            ctrl_rd_data_q <= ctrl_rdata;
        end
    end

    assign data_ack   = ack_q;
    assign data_rdata = ctrl_rd_q ? ctrl_rd_data_q : ram_bus.rdata;

    // Stack pointer: loaded by software, moved by pushes and pops.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            sp_q <= 8'h00;
        else if (state_q == DMSM_ST_PUSH)
            sp_q <= sp_q - 8'h01;
        else if (state_q == DMSM_ST_IDLE &&
                 (stack_op == DMSM_OP_RET || stack_op == DMSM_OP_INTERRUPT_RETURN_INSTR))
            sp_q <= sp_q + 8'h01;
        else if (state_q == DMSM_ST_POPW && left_q != 2'd0)
            sp_q <= sp_q + 8'h01;
        else if (state_q == DMSM_ST_IDLE && stack_pointer_load &&
                 stack_op == DMSM_OP_NONE)
            sp_q <= stack_pointer_value;
    end

    assign stack_pointer = sp_q;

    // Sequencer for pushes and pops, one byte per step.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= DMSM_ST_IDLE;
            left_q  <= 2'd0;
            total_q <= 2'd0;
            shreg_q <= 24'h000000;
            flags_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                DMSM_ST_IDLE:
                begin
                    case (stack_op)
                        DMSM_OP_CALL:
                        begin
                            // High byte first, then low byte.
                            shreg_q <= {program_counter, 8'h00};
                            left_q  <= 2'd1;
                            total_q <= 2'd0;
                            flags_q <= 1'b0;
                            state_q <= DMSM_ST_PUSH;
                        end
                        DMSM_OP_IRQ:
                        begin
                            // Return address, then the flags.
                            shreg_q <= {program_counter, status_flags};
                            left_q  <= 2'd2;
                            total_q <= 2'd0;
                            flags_q <= 1'b1;
                            state_q <= DMSM_ST_PUSH;
                        end
                        DMSM_OP_RET:
                        begin
                            left_q  <= 2'd1;
                            total_q <= 2'd1;
                            flags_q <= 1'b0;
                            state_q <= DMSM_ST_POPA;
                        end
                        DMSM_OP_INTERRUPT_RETURN_INSTR:
                        begin
                            left_q  <= 2'd2;
                            total_q <= 2'd2;
                            flags_q <= 1'b1;
                            state_q <= DMSM_ST_POPA;
                        end
                        default:
                            state_q <= DMSM_ST_IDLE;
                    endcase
                end
                DMSM_ST_PUSH:
                begin
                    shreg_q <= {shreg_q[15:0], 8'h00};
                    left_q  <= left_q - 2'd1;
                    if (left_q == 2'd0)
                        state_q <= DMSM_ST_DONE;
                end
                DMSM_ST_POPA:
                    state_q <= DMSM_ST_POPW;
                DMSM_ST_POPW:
                begin
                    // Pops the flags (interrupt return only), then low, then high byte.
                    shreg_q <= {ram_bus.rdata, shreg_q[23:8]};
                    left_q  <= left_q - 2'd1;
                    if (left_q == 2'd0)
                        state_q <= DMSM_ST_DONE;
                    else
                        state_q <= DMSM_ST_POPA;
                end
                DMSM_ST_DONE:
                    state_q <= DMSM_ST_IDLE;
                default:
                    state_q <= DMSM_ST_IDLE;
            endcase
        end
    end

    // Results: vector on interrupt accept, restored state on returns.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vec_q  <= `DMSM_VEC_BASE;
            rpc_q  <= 16'h0000;
            rfl_q  <= 8'h00;
            rflv_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= state_q == DMSM_ST_DONE;
            rflv_q <= 1'b0;
            if (state_q == DMSM_ST_IDLE && stack_op == DMSM_OP_IRQ)
                vec_q <= `DMSM_VEC_BASE + {11'h000, irq_src, 1'b0};
            else if (state_q == DMSM_ST_IDLE && stack_op == DMSM_OP_CALL)
                vec_q <= 16'h0000;
            if (state_q == DMSM_ST_DONE && total_q != 2'd0)
            begin
                rpc_q <= shreg_q[23:8];
                if (flags_q)
                begin
                    rfl_q  <= shreg_q[7:0];
                    rflv_q <= 1'b1;
                end
            end
        end
    end

    assign stack_busy           = state_q != DMSM_ST_IDLE;
    assign stack_done           = done_q;
    assign vector_addr          = vec_q;
    assign restored_pc          = rpc_q;
    assign restored_flags       = rfl_q;
    assign restored_flags_valid = rflv_q;
endmodule // dmsm_top
`default_nettype wire

// ---- verification/dmsm_periph_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Peripheral register bank seen through the control window.
module dmsm_periph_model #(
    parameter int IMPL = 48
) (
    input  wire logic       clock,
    input  wire logic       ctrl_sel,
    input  wire logic       ctrl_we,
    input  wire logic [5:0] ctrl_index,
    input  wire logic [7:0] ctrl_wdata,
    output logic      [7:0] ctrl_rdata
);
    logic [7:0] regs [64];
    logic [7:0] noise_q = 8'h5a;
    // Backed registers take whole-byte writes; the noise moves each cycle.
    always_ff @(posedge clock)
    begin
        noise_q <= noise_q + 8'h3b;
        if (ctrl_sel && ctrl_we && ctrl_index < IMPL)
            regs[ctrl_index] <= ctrl_wdata;
    end
    // Unbacked or unselected reads never repeat the last value.
    assign ctrl_rdata = (ctrl_sel && ctrl_index < IMPL) ? regs[ctrl_index]
                      : noise_q;
endmodule // dmsm_periph_model
`default_nettype wire

// ---- verification/dmsm_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// Watches the top-level ports of the data-memory block.
module dmsm_top_sva (
    input wire logic               clock,
    input wire logic               arst_n,
    input wire logic               data_req,
    input wire logic [8:0]         data_addr,
    input wire logic [7:0]         data_rdata,
    input wire logic               data_ack,
    input wire logic               ctrl_sel,
    input wire logic               ctrl_we,
    input wire logic [7:0]         ctrl_rdata,
    input wire logic               stack_pointer_load,
    input wire logic [7:0]         stack_pointer_value,
    input wire logic [7:0]         stack_pointer,
    input wire dmsm_pkg::dmsm_op_e stack_op,
    input wire logic               stack_busy,
    input wire logic               stack_done
);
    import dmsm_pkg::*;
    logic       take;
    logic       in_win;
    dmsm_op_e   op_q;
    logic [7:0] sp_q;
    logic [7:0] sp_exp;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    // An operation starts whenever one is requested while the sequencer is idle.
    assign take = !stack_busy && stack_op != DMSM_OP_NONE;
    assign in_win = data_addr >= 9'h0c0 && data_addr <= 9'h0ff;
    // Keeps the last operation and the pointer it started from.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            op_q <= DMSM_OP_NONE;
            sp_q <= 8'h00;
        end
        else if (take)
        begin
            op_q <= stack_op;
            sp_q <= stack_pointer;
        end
    end
    // Pointer expected once the operation has finished.
    assign sp_exp = (op_q == DMSM_OP_CALL) ? sp_q - 8'h02
                  : (op_q == DMSM_OP_IRQ) ? sp_q - 8'h03
                  : (op_q == DMSM_OP_RET) ? sp_q + 8'h02 : sp_q + 8'h03;
    ack_after_req_a: assert property (
        data_req && !stack_busy |=> data_ack) else $error("ack missing");
    win_decode_a: assert property (
        ctrl_sel == (data_req && !stack_busy && in_win)) else $error("sel");
    win_rdata_a: assert property (
        ctrl_sel && !ctrl_we |=> data_rdata == $past(ctrl_rdata))
        else $error("window read data");
    call_time_a: assert property (
        take && stack_op == DMSM_OP_CALL |-> ##[4:5] stack_done)
        else $error("call late");
    irq_time_a: assert property (
        take && stack_op == DMSM_OP_IRQ |-> ##[5:6] stack_done)
        else $error("irq late");
    ret_time_a: assert property (
        take && stack_op == DMSM_OP_RET |-> ##[5:6] stack_done)
        else $error("return late");
    interrupt_return_instr_time_a: assert property (
        take && stack_op == DMSM_OP_INTERRUPT_RETURN_INSTR |-> ##[7:8] stack_done)
        else $error("irq return late");
    sp_step_a: assert property (
        $fell(stack_busy) |-> stack_pointer == sp_exp) else $error("sp step");
    sp_load_a: assert property (
        stack_pointer_load && !take && !stack_busy
        |=> stack_pointer == $past(stack_pointer_value)) else $error("sp load");
    // Main scenarios reached.
    cover property (take && stack_op == DMSM_OP_INTERRUPT_RETURN_INSTR);
    cover property (ctrl_sel && ctrl_we);
    cover property ($fell(stack_busy) && op_q == DMSM_OP_IRQ);
endmodule // dmsm_top_sva
bind dmsm_top dmsm_top_sva i_sva (.clock, .arst_n, .data_req, .data_addr,
    .data_rdata, .data_ack, .ctrl_sel, .ctrl_we, .ctrl_rdata,
    .stack_pointer_load, .stack_pointer_value, .stack_pointer, .stack_op,
    .stack_busy, .stack_done);
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dmsm_consts.svh"
module tb_top;
    import dmsm_pkg::*;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        data_req = 1'b0;
    logic        data_we = 1'b0;
    logic        stack_pointer_load = 1'b0;
    logic [8:0]  data_addr = '0;
    logic [7:0]  data_wdata = '0;
    logic [7:0]  stack_pointer_value = '0;
    logic [7:0]  status_flags = '0;
    logic [15:0] program_counter = '0;
    dmsm_op_e    stack_op = DMSM_OP_NONE;
    dmsm_src_e   irq_src = DMSM_SRC_RESET;
    logic        data_ack, ctrl_sel, ctrl_we, stack_busy, stack_done, rfv;
    logic [7:0]  data_rdata, ctrl_wdata, ctrl_rdata, stack_pointer, rflags;
    logic [5:0]  ctrl_index;
    logic [15:0] vector_addr, restored_pc;
    int          n_errors = 0;
    int          n_compared = 0;
    dmsm_top i_dut (.clock, .arst_n, .data_req, .data_we, .data_addr,
        .data_wdata, .data_rdata, .data_ack, .ctrl_sel, .ctrl_we, .ctrl_index,
        .ctrl_wdata, .ctrl_rdata, .stack_pointer_load, .stack_pointer_value,
        .stack_pointer, .stack_op, .irq_src, .program_counter, .status_flags,
        .stack_busy, .stack_done, .vector_addr, .restored_pc,
        .restored_flags(rflags), .restored_flags_valid(rfv));
    dmsm_periph_model i_periph (.clock, .ctrl_sel, .ctrl_we, .ctrl_index,
        .ctrl_wdata, .ctrl_rdata);
    // Free-running system clock.
    initial
    begin
        forever #10 clock = ~clock;
    end
    // Vector slot address for an interrupt source, from the slot table.
    function automatic logic [15:0] vexp(input dmsm_src_e s);
        logic [3:0] slot;
        case (s)
            DMSM_SRC_SERIAL:    slot = `DMSM_VEC_SERIAL;
            DMSM_SRC_INTERVAL:  slot = `DMSM_VEC_INTERVAL;
            DMSM_SRC_WATCHDOG:  slot = `DMSM_VEC_WATCHDOG;
            DMSM_SRC_CONVERTER: slot = `DMSM_VEC_CONVERTER;
            DMSM_SRC_TIMER1:    slot = `DMSM_VEC_TIMER1;
            DMSM_SRC_TIMER0:    slot = `DMSM_VEC_TIMER0;
            DMSM_SRC_EXT1:      slot = `DMSM_VEC_EXT1;
            DMSM_SRC_EXT0:      slot = `DMSM_VEC_EXT0;
            default:            slot = `DMSM_VEC_RESET;
        endcase
        return `DMSM_VEC_BASE + {11'h000, slot, 1'b0};
    endfunction
    task automatic results;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    // Waits a bounded time for the acknowledge or the done pulse.
    task automatic wait_hi(input bit on_done);
        int i;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clock);
            #1;
            if ((on_done ? stack_done : data_ack) === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_errors++;
            results();
        end
    endtask
    task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        data_req = 1'b1;
        data_we = w;
        data_addr = a;
        data_wdata = d;
        wait_hi(1'b0);
        data_req = 1'b0;
    endtask
    task automatic op(input dmsm_op_e o, input dmsm_src_e s,
                      input logic [15:0] pc, input logic [7:0] f);
        @(posedge clock);
        #1;
        stack_op = o;
        irq_src = s;
        program_counter = pc;
        status_flags = f;
        @(posedge clock);
        #1;
        stack_op = DMSM_OP_NONE;
        wait_hi(1'b1);
    endtask
    task automatic ld(input logic [7:0] v);
        @(posedge clock);
        #1;
        stack_pointer_load = 1'b1;
        stack_pointer_value = v;
        @(posedge clock);
        #1;
        stack_pointer_load = 1'b0;
    endtask
    // Main sequence.
    initial
    begin
        logic [8:0]  a [10];
        logic [7:0]  d [10];
        logic [7:0]  sp0;
        logic [15:0] pc;
        dmsm_src_e   s;
        void'($urandom(56));
        repeat (2) @(posedge clock);
        #1 arst_n = 1'b1;
        chk("sp_reset", 16'h0000, {8'h00, stack_pointer});
        chk("vec_reset", 16'hffe0, vector_addr);
        a[0] = 9'h000;
        a[1] = 9'h0bf;
        a[2] = 9'h100;
        a[3] = 9'h1ff;
        for (int i = 4; i < 10; i++)
            a[i] = (i < 7 ? 9'h000 : 9'h100) + 9'(i * 16 + $urandom_range(0, 15));
        foreach (a[i]) d[i] = 8'($urandom);
        foreach (a[i]) acc(1'b1, a[i], d[i]);
        for (int k = 0; k < 4; k++)
        begin
            sp0 = 8'($urandom);
            acc(1'b1, 9'h0c0 + 9'(k * 12 + $urandom_range(0, 11)), sp0);
            acc(1'b0, data_addr, 8'h00);
            chk("window", {8'h00, sp0}, {8'h00, data_rdata});
        end
        acc(1'b0, 9'h0ff, 8'h00);
        foreach (a[i])
        begin
            acc(1'b0, a[i], 8'h00);
            chk("ram", {8'h00, d[i]}, {8'h00, data_rdata});
        end
        ld(8'h80);
        pc = 16'($urandom);
        op(DMSM_OP_CALL, DMSM_SRC_RESET, pc, 8'h00);
        chk("sp_call", 16'h007e, {8'h00, stack_pointer});
        acc(1'b0, 9'h180, 8'h00);
        chk("push_hi", {8'h00, pc[15:8]}, {8'h00, data_rdata});
        acc(1'b0, 9'h17f, 8'h00);
        chk("push_lo", {8'h00, pc[7:0]}, {8'h00, data_rdata});
        op(DMSM_OP_RET, DMSM_SRC_RESET, 16'h0000, 8'h00);
        chk("ret_pc", pc, restored_pc);
        chk("ret_flag_pulse", 16'h0000, {15'h0000, rfv});
        chk("sp_ret", 16'h0080, {8'h00, stack_pointer});
        s = s.first();
        repeat (s.num())
        begin
            sp0 = (s == DMSM_SRC_SERIAL) ? 8'hff
                                         : 8'($urandom_range(3, 255));
            pc = 16'($urandom);
            d[0] = 8'($urandom);
            ld(sp0);
            op(DMSM_OP_IRQ, s, pc, d[0]);
            chk("vector", vexp(s), vector_addr);
            chk("irq_flag_pulse", 16'h0000, {15'h0000, rfv});
            chk("sp_irq", {8'h00, sp0 - 8'h03}, {8'h00, stack_pointer});
            acc(1'b0, {1'b1, sp0 - 8'h02}, 8'h00);
            chk("push_flags", {8'h00, d[0]}, {8'h00, data_rdata});
            op(DMSM_OP_INTERRUPT_RETURN_INSTR, DMSM_SRC_RESET, 16'h0000, 8'h00);
            chk("interrupt_return_instr_pc", pc, restored_pc);
            chk("interrupt_return_instr_flags", {8'h00, d[0]}, {8'h00, rflags});
            chk("interrupt_return_instr_flag_pulse", 16'h0001, {15'h0000, rfv});
            chk("sp_interrupt_return_instr", {8'h00, sp0}, {8'h00, stack_pointer});
            s = s.next();
        end
        results();
    end
endmodule // tb_top
`default_nettype wire
